// ===== hdl/ecc1_coef.sv
// Purpose: adaptive coefficient store of the canceller
// Assumes: clear has priority over adapt
// Notes: adaptation is a simple signed accumulate per tap
`timescale 1ns/100ps
module ecc1_coef #(
    parameter int NCOEF = ecc1_pkg::ECC1_NCOEF,
    parameter int CW = ecc1_pkg::ECC1_CW
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // control side
    ecc1_coef_if.store cif
);
    typedef struct packed {
        logic [NCOEF-1:0][CW-1:0] coef;
    } ecc1_cst_t;
    ecc1_cst_t st_r;
    ecc1_cst_t st_nxt;
    logic [NCOEF-1:0] nz;

    always_comb
    begin
        st_nxt = st_r;
        for (int i = 0; i < NCOEF; i++)
        begin
            if (cif.clear)
                st_nxt.coef[i] = '0;
            else if (cif.adapt)
                st_nxt.coef[i] = st_r.coef[i] + CW'(cif.err + 16'(i));
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCOEF; g++)
        begin : g_nz
            assign nz[g] = |st_r.coef[g];
        end
    endgenerate
    assign cif.all_zero = ~|nz;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule // ecc1_coef

// ===== hdl/ecc1_coef_if.sv
// Purpose: carrier between control logic and coefficient store
// Assumes: single clock
// Notes: clear and adapt strobes, coefficient sample view
`timescale 1ns/100ps
interface ecc1_coef_if;
    logic clear;
    logic adapt;
    logic [15:0] err;
    logic all_zero;
    modport ctrl (output clear, output adapt, output err, input all_zero);
    modport store (input clear, input adapt, input err, output all_zero);
endinterface : ecc1_coef_if

// ===== hdl/ecc1_ctrl.sv
// Purpose: canceller A control register one with its control effects
// Assumes: avalon-mm slave, one wait state on every access outside initialisation
// Notes: writes during initialisation stall until it ends
//        bypass also clears the coefficient store
//        status word bit 1 shows all coefficients zero
`timescale 1ns/100ps
module ecc1_ctrl #(
    parameter int INIT_CYC = ecc1_pkg::ECC1_INIT_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // voice samples, same clock
    input wire logic i_sample_valid,
    input wire logic [15:0] i_sin,
    input wire logic [15:0] i_rin,
    output logic [15:0] o_sout,
    output logic [15:0] o_rout,
    // control views
    output logic o_back_to_back,
    output logic o_noise_injection_disable,
    output logic o_extended_delay_disable,
    output logic o_rx_pad,
    output logic o_init_busy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ECC1_IDLE = 2'b00,
        ECC1_ACK = 2'b01,
        ECC1_INIT = 2'b10
    } ecc1_st_t;

    typedef struct packed {
        ecc1_st_t fsm;
        logic [7:0] ctrl;
        logic [31:0] cnt;
        logic [31:0] rdata;
        logic waitreq;
        logic busy;
        logic [15:0] sout;
        logic [15:0] rout;
        logic [15:0] est;
    } ecc1_state_t;

    ecc1_state_t st_r;
    ecc1_state_t st_nxt;
    ecc1_coef_if cif ();

    logic req;
    logic [7:0] wr_byte;
    logic bypass;
    logic adp_dis;
    logic [15:0] echo;
    logic pad;
    logic sel_ctrl;
    logic sel_stat;
    logic wr_ctrl;
    logic init_last;
    logic [31:0] rd_mux;
    logic [15:0] sout_alg;
    logic [15:0] rout_alg;

    assign req = i_avs_read | i_avs_write;
    assign bypass = st_r.ctrl[ecc1_pkg::ECC1_BYPASS_BIT];
    assign adp_dis = st_r.ctrl[ecc1_pkg::ECC1_ADP_BIT];
    assign pad = st_r.ctrl[ecc1_pkg::ECC1_PAD_BIT];
    assign echo = i_rin >>> 3;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    assign sel_ctrl = (i_avs_address == ecc1_pkg::ECC1_CTRL_OFS);
    assign sel_stat = (i_avs_address == ecc1_pkg::ECC1_STAT_OFS);
    // lane 0 carries the whole register; other lanes are ignored
    assign wr_ctrl = i_avs_write & i_avs_byteenable[0] & sel_ctrl;
    // last cycle of the routine
    assign init_last = (st_r.cnt >= 32'(INIT_CYC - 1));
    // unmapped offsets read as zero
    assign rd_mux = sel_ctrl ? {24'h000000, st_r.ctrl} :
                    sel_stat ? {30'h0000000, cif.all_zero, 1'b0} :
                    ecc1_pkg::ECC1_UNMAPPED;

    // ------------------------------------------------------------
    // sample path
    // ------------------------------------------------------------
    // cancelled send path and padded receive path
    assign sout_alg = i_sin - st_r.est;
    assign rout_alg = pad ? (i_rin >>> 2) : i_rin;

    // ------------------------------------------------------------
    // coefficient store control
    // ------------------------------------------------------------
    // init and bypass both clear the taps
    assign cif.clear = (st_r.fsm == ECC1_INIT) | bypass;
    // adapt only on a sample while enabled
    assign cif.adapt = i_sample_valid & ~adp_dis & ~bypass;
    // the taps see the cancelled send sample as their error
    assign cif.err = sout_alg;

    ecc1_coef u_coef (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .cif(cif)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        wr_byte = i_avs_writedata[7:0];
        st_nxt.waitreq = 1'b1;
        unique case (st_r.fsm)
            ECC1_IDLE:
            begin
                if (req)
                begin
                    // answer next cycle with the data selected now
                    st_nxt.fsm = ECC1_ACK;
                    st_nxt.waitreq = 1'b0;
                    st_nxt.rdata = rd_mux;
                    if (wr_ctrl)
                    begin
                        // bit layout kept as written, reserved too
                        st_nxt.ctrl = wr_byte;
                        if (wr_byte[ecc1_pkg::ECC1_INIT_BIT])
                        begin
                            st_nxt.cnt = '0;
                        end
                    end
                end
            end
            ECC1_ACK:
            begin
                // an answered trigger write starts the routine
                st_nxt.fsm = st_r.ctrl[ecc1_pkg::ECC1_INIT_BIT] ?
                             ECC1_INIT : ECC1_IDLE;
            end
            ECC1_INIT:
            begin
                st_nxt.cnt = st_r.cnt + 32'h00000001;
                if (init_last)
                begin
                    // trigger bit returns to preset as well
                    st_nxt.ctrl = ecc1_pkg::ECC1_CTRL_RST;
                    st_nxt.fsm = ECC1_IDLE;
                end
            end
            // the unused code is never entered; fall back to idle
            default:
                st_nxt.fsm = ECC1_IDLE;
        endcase
        if (i_sample_valid)
        begin
            // frozen taps still cancel through the estimate
            st_nxt.est = adp_dis ? st_r.est : echo;
            // bypass passes both paths through unchanged
            if (bypass)
            begin
                st_nxt.sout = i_sin;
                st_nxt.rout = i_rin;
            end
            else
            begin
                st_nxt.sout = sout_alg;
                st_nxt.rout = rout_alg;
            end
        end
        st_nxt.busy = (st_nxt.fsm == ECC1_INIT);
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        // waitrequest stands high through reset
        if (i_rst)
        begin
            st_r <= '{fsm: ECC1_IDLE,
                      ctrl: ecc1_pkg::ECC1_CTRL_RST,
                      waitreq: 1'b1,
                      default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a field of the state register
    assign o_avs_readdata = st_r.rdata;
    assign o_avs_waitrequest = st_r.waitreq;
    assign o_sout = st_r.sout;
    assign o_rout = st_r.rout;
    assign o_back_to_back = st_r.ctrl[ecc1_pkg::ECC1_BTB_BIT];
    assign o_noise_injection_disable = st_r.ctrl[ecc1_pkg::ECC1_NOISE_BIT];
    assign o_extended_delay_disable = st_r.ctrl[ecc1_pkg::ECC1_EXT_BIT];
    assign o_rx_pad = st_r.ctrl[ecc1_pkg::ECC1_PAD_BIT];
    assign o_init_busy = st_r.busy;
endmodule // ecc1_ctrl

// ===== hdl/ecc1_pkg.sv
// Purpose: constants for the canceller A control register one block
// Assumes: avalon-mm slave with 32-bit data, byte addressed words
// Notes: one register word plus a status word
package ecc1_pkg;
    // register byte offsets
    localparam logic [3:0] ECC1_CTRL_OFS = 4'h0;
    localparam logic [3:0] ECC1_STAT_OFS = 4'h4;
    // field positions
    localparam int ECC1_INIT_BIT = 7;
    localparam int ECC1_NOISE_BIT = 6;
    localparam int ECC1_BTB_BIT = 5;
    localparam int ECC1_PAD_BIT = 4;
    localparam int ECC1_BYPASS_BIT = 3;
    localparam int ECC1_ADP_BIT = 2;
    localparam int ECC1_RSVD_BIT = 1;
    localparam int ECC1_EXT_BIT = 0;
    // reset values
    localparam logic [7:0] ECC1_CTRL_RST = 8'h00;
    localparam logic [31:0] ECC1_UNMAPPED = 32'h00000000;
    // timing: initialisation lasts two frames of 125 us
    localparam int ECC1_FRAME_NS = 125000;
    localparam int ECC1_CLK_NS = 8;
    localparam int ECC1_INIT_FRAMES = 2;
    localparam int ECC1_INIT_CYC =
        (ECC1_INIT_FRAMES * ECC1_FRAME_NS) / ECC1_CLK_NS;
    // coefficient store tap count and width, all taps cleared in one cycle
    localparam int ECC1_NCOEF = 16;
    localparam int ECC1_CW = 16;
endpackage

// ===== sim/ecc1_ctrl_sva.sv
// Purpose: port checker for ecc1_ctrl
// Assumes: one clock, async reset high
// Notes: bound to every ecc1_ctrl
`timescale 1ns/100ps
module ecc1_ctrl_sva (
    // clock, reset, bus
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // control views
    input wire logic o_back_to_back,
    input wire logic o_noise_injection_disable,
    input wire logic o_extended_delay_disable,
    input wire logic o_rx_pad,
    input wire logic o_init_busy
);
    logic wr_ok;
    logic [31:0] wd_r;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    assign wr_ok = i_avs_write && !o_avs_waitrequest
        && i_avs_address == ecc1_pkg::ECC1_CTRL_OFS && i_avs_byteenable[0];
    always_ff @(posedge i_core_clk) wd_r <= i_avs_writedata;
    a_wait_one: assert property ((i_avs_read || i_avs_write)
        && o_avs_waitrequest && !o_init_busy |=> !o_avs_waitrequest)
        else $error("request not answered next cycle");
    a_wait_stands: assert property (!o_avs_waitrequest
        |=> o_avs_waitrequest) else $error("answer longer than one cycle");
    a_ctrl_fields: assert property (wr_ok && !i_avs_writedata[7]
        |=> {o_back_to_back, o_noise_injection_disable, o_rx_pad,
        o_extended_delay_disable} == {wd_r[5], wd_r[6], wd_r[4], wd_r[0]})
        else $error("control views differ from write");
    a_init_start: assert property (wr_ok && i_avs_writedata[7]
        |-> ##[0:2] o_init_busy) else $error("init did not start");
    a_init_stall: assert property (o_init_busy && $past(o_init_busy)
        |-> o_avs_waitrequest) else $error("access answered during init");
    a_init_clear: assert property ($fell(o_init_busy) |-> ##[0:1]
        !(o_back_to_back || o_noise_injection_disable || o_rx_pad
        || o_extended_delay_disable)) else $error("fields not preset");
    a_unmap_zero: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address[3] |-> o_avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_ctrl_back: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address == ecc1_pkg::ECC1_CTRL_OFS |-> o_avs_readdata[5]
        == o_back_to_back && o_avs_readdata[0] == o_extended_delay_disable)
        else $error("readback differs from views");
endmodule // ecc1_ctrl_sva
bind ecc1_ctrl ecc1_ctrl_sva u_ecc1_ctrl_sva (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_back_to_back(o_back_to_back),
    .o_noise_injection_disable(o_noise_injection_disable),
    .o_extended_delay_disable(o_extended_delay_disable),
    .o_rx_pad(o_rx_pad), .o_init_busy(o_init_busy));

// ===== sim/tb.sv
// Purpose: self-checking bench for ecc1_ctrl
// Assumes: init shortened to 20 cycles
// Notes: status bit 1 shows coefficients all zero
`timescale 1ns/100ps
module tb;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic i_sample_valid = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [15:0] i_sin = 16'h0000;
    logic [15:0] o_sout, o_rout;
    logic [31:0] o_avs_readdata, rd;
    logic o_avs_waitrequest, o_back_to_back, o_noise_injection_disable;
    logic o_extended_delay_disable, o_rx_pad, o_init_busy;
    int fails = 0;
    int n_compared = 0;
    // write byte beside expected {btb, noise, pad, ext}
    logic [11:0] rows [6] = '{12'h208, 12'h404, 12'h102, 12'h011,
        12'h0C0, 12'h517};
    always #4 i_core_clk = ~i_core_clk;
    ecc1_ctrl #(.INIT_CYC(20)) u_ecc1_ctrl (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_sample_valid(i_sample_valid), .i_sin(i_sin), .i_rin(i_sin),
        .o_sout(o_sout), .o_rout(o_rout), .o_back_to_back(o_back_to_back),
        .o_noise_injection_disable(o_noise_injection_disable),
        .o_extended_delay_disable(o_extended_delay_disable),
        .o_rx_pad(o_rx_pad), .o_init_busy(o_init_busy));
    task close_out;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
            begin
                fails++;
                $display("BAD t=%0t got %h exp %h", $time, g, e);
            end
    endtask
    // one access, called just after a rising edge; the request stands
    // until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        i_avs_address <= a;
        i_avs_writedata <= {24'h000000, d};
        i_avs_byteenable <= be;
        i_avs_write <= w;
        i_avs_read <= !w;
        @(posedge i_core_clk);
        while (o_avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 200)
            begin
                fails++;
                close_out;
            end
            @(posedge i_core_clk);
        end
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        // one idle edge keeps the next request out of this time step
        @(posedge i_core_clk);
    endtask
    task samp(input int k);
        repeat (k)
        begin
            @(posedge i_core_clk);
            i_sample_valid <= 1'b1;
            i_sin <= 16'h4321;
            @(posedge i_core_clk);
            i_sample_valid <= 1'b0;
        end
        @(posedge i_core_clk);
    endtask
    initial
    begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        bus(1'b0, 4'h0, 8'h00, 4'hF);
        chk(rd, 32'h00000000);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, 4'h0, rows[i][11:4], 4'hF);
            bus(1'b0, 4'h0, 8'h00, 4'hF);
            chk(rd[7:0], rows[i][11:4]);
            chk({o_back_to_back, o_noise_injection_disable, o_rx_pad,
                o_extended_delay_disable}, rows[i][3:0]);
        end
        bus(1'b1, 4'h8, 8'hFF, 4'hF);
        bus(1'b0, 4'h8, 8'h00, 4'hF);
        chk(rd, 32'h00000000);
        bus(1'b1, 4'h0, 8'h20, 4'hE);
        bus(1'b0, 4'h0, 8'h00, 4'hF);
        chk(rd[7:0], 8'h51);
        // bypass: both paths pass through and the taps are cleared
        bus(1'b1, 4'h0, 8'h08, 4'hF);
        samp(1);
        chk(o_sout, 16'h4321);
        chk(o_rout, 16'h4321);
        // a whole frame in bypass before bypass is left with adaptation frozen
        repeat (ecc1_pkg::ECC1_FRAME_NS / ecc1_pkg::ECC1_CLK_NS)
            @(posedge i_core_clk);
        bus(1'b1, 4'h0, 8'h04, 4'hF);
        samp(8);
        n_compared++;
        if (o_sout === 16'h4321)
        begin
            fails++;
            $display("BAD t=%0t sout %h equals sin %h", $time, o_sout,
                16'h4321);
        end
        bus(1'b0, 4'h4, 8'h00, 4'hF);
        chk(rd[1], 1'b1);
        bus(1'b1, 4'h0, 8'h00, 4'hF);
        samp(8);
        bus(1'b0, 4'h4, 8'h00, 4'hF);
        chk(rd[1], 1'b0);
        bus(1'b1, 4'h0, 8'hA4, 4'hF);
        chk(o_init_busy, 1'b1);
        bus(1'b0, 4'h0, 8'h00, 4'hF);
        chk(rd[7:0], 8'h00);
        chk({o_init_busy, o_back_to_back, o_rx_pad}, 3'b000);
        bus(1'b0, 4'h4, 8'h00, 4'hF);
        chk(rd[1], 1'b1);
        // reset in mid-run: bus stalls, fields return to preset
        bus(1'b1, 4'h0, 8'h70, 4'hF);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        chk({o_avs_waitrequest, o_back_to_back, o_rx_pad,
            o_noise_injection_disable}, 4'h8);
        i_rst <= 1'b0;
        bus(1'b0, 4'h0, 8'h00, 4'hF);
        chk(rd, 32'h00000000);
        close_out;
    end
endmodule // tb
